// file: include/dus_pkg.sv
// dus_pkg: constants for the dac update sequencer
// assumes a 250 MHz system clock and a plain register port
//
// Function
// - reset input low disconnects all outputs and ties them to ground ref.
// - reset rise runs 300 us default restore; host must not write then.
// - after restore with clear high, outputs sit at ground reference level.
// - outputs stay at ground until a register write and then a load strobe; the sequencer releases them on any load strobe, with or without a write.
// - clear low grounds outputs and ignores load strobes meanwhile.
// - after clear rises, outputs stay cleared until next load strobe.
// - clear never alters input registers or dac registers.
// - busy low while computing; writes accepted, no output update.
// - load strobe during busy is latched; update right after busy rises.
// - source select write holds busy low about 500 ns.
// - busy is wired; line held low elsewhere still counts as busy.
// - one shared engine computes channels in turn: 1, 5, 8 or 40.
// - busy lasts at most (channels+1) x 500 ns + 250 ns.
// - load updates only channels whose calibrated word changed since last load.
// - control bit 0 powers down and grounds all outputs.
// - power-down keeps registers; clearing it restores previous outputs.
// - offset trim default is 32768.
// - gain trim default is 65535.
// - calibrated = input*(gain+1)/2^16 + offset - 2^15.
// - bank bit picks whether word a or b is recomputed.
// - load takes word a or b per source select bit, 0 selects a.
package dus_pkg;
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned NUM_CH         = 40;
  localparam int unsigned GRP_CH         = 8;
  localparam int unsigned NUM_GRP        = 5;
  localparam int unsigned RESET_SEQ_US   = 300;
  localparam int unsigned STAGE_NS       = 500;
  localparam int unsigned TAIL_NS        = 250;
  localparam int unsigned RESET_SEQ_CYC  = RESET_SEQ_US * CLK_MHZ;
  localparam int unsigned STAGE_CYC      = STAGE_NS * CLK_MHZ / 1000;
  localparam int unsigned TAIL_CYC       = TAIL_NS * CLK_MHZ / 1000;
  localparam logic [15:0] INPUT_DEFAULT  = 16'h5554;
  localparam logic [15:0] GAIN_DEFAULT   = 16'hFFFF;
  localparam logic [15:0] OFFSET_DEFAULT = 16'h8000;
  localparam logic [15:0] DAC_DEFAULT    = 16'h5554;
  // register port map
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h01;
  localparam logic [7:0]  ADDR_SRCSEL    = 8'h08;  // 8..12, one per group
  localparam logic [7:0]  ADDR_INPUT     = 8'h40;  // write targets by mode
  localparam int unsigned CTRL_PD_BIT    = 0;
  localparam int unsigned CTRL_BANK_BIT  = 2;
  // write data layout: [15:0] value, [17:16] kind, [23:18] channel, [25:24] fan
  localparam logic [1:0]  KIND_INPUT     = 2'b11;
  localparam logic [1:0]  KIND_OFFSET    = 2'b10;
  localparam logic [1:0]  KIND_GAIN      = 2'b01;
  localparam logic [1:0]  FAN_ONE        = 2'b00;
  localparam logic [1:0]  FAN_GROUP      = 2'b01;
  localparam logic [1:0]  FAN_ACROSS     = 2'b10;
  localparam logic [1:0]  FAN_ALL        = 2'b11;
  typedef enum logic [1:0] {DUS_RESTORE, DUS_IDLE, DUS_CALC, DUS_TAIL} dus_state_t;
endpackage : dus_pkg

// file: core/dus_sequencer.sv
// dus_sequencer: busy, load, clear, reset and power-down control for forty channels
// assumes pins arrive asynchronously; register port is on clk_sys_i
`timescale 1ns/1ns
`default_nettype none
module dus_sequencer (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        reset_pin_n_i,      // device reset pin, active low
  input  wire logic        zero_outputs_n_i,
  input  wire logic        load_outputs_n_i,
  input  wire logic        busy_n_i,           // wired busy line level
  output logic             busy_n_o,
  output logic             busy_n_oe_o,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  output logic             out_connect_o,      // output buffers connected
  output logic [39:0]      out_ground_o,       // per channel tie to ground ref
  output logic [639:0]     channel_outputs_o,  // forty dac registers
  output logic             powered_down_o
);
  import dus_pkg::*;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [1:0] rst_s_reg, clr_s_reg, ld_s_reg, bsy_s_reg;
  logic       ld_prev_reg;
  always_ff @(posedge clk_sys_i) begin
    rst_s_reg <= {rst_s_reg[0], reset_pin_n_i};
    clr_s_reg <= {clr_s_reg[0], zero_outputs_n_i};
    ld_s_reg  <= {ld_s_reg[0], load_outputs_n_i};
    bsy_s_reg <= {bsy_s_reg[0], busy_n_i};
    ld_prev_reg <= ld_s_reg[1];
  end
  wire rst_pin_low = !rst_s_reg[1];
  wire clr_low     = !clr_s_reg[1];
  wire ld_level    = !ld_s_reg[1];
  wire ld_fall     = ld_prev_reg && !ld_s_reg[1];

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  logic [15:0] in_a_reg [NUM_CH];
  logic [15:0] in_b_reg [NUM_CH];
  logic [15:0] gain_a_reg [NUM_CH];
  logic [15:0] gain_b_reg [NUM_CH];
  logic [15:0] off_a_reg [NUM_CH];
  logic [15:0] off_b_reg [NUM_CH];
  logic [15:0] cal_a_reg [NUM_CH];
  logic [15:0] cal_b_reg [NUM_CH];
  logic [15:0] dac_reg [NUM_CH];
  logic [39:0] srcsel_reg;
  logic [39:0] pend_a_reg, pend_b_reg;   // channels awaiting calculation
  logic [39:0] changed_reg;              // calibrated word changed since load
  logic [2:0]  ctrl_reg;
  logic        cleared_reg;              // outputs grounded until next load
  logic        ld_pend_reg;
  logic        sel_busy_reg;
  dus_state_t  state_reg;
  logic [31:0] cnt_reg;
  logic [5:0]  ch_reg;
  logic        bank_cur_reg;

  // calibrated word from input, gain and offset
  function automatic logic [15:0] calib(input logic [15:0] x, input logic [15:0] m,
                                        input logic [15:0] c);
    logic [32:0] prod;
    logic [17:0] sum;
    prod = 33'(x) * (33'(m) + 33'd1);
    sum  = 18'(prod[32:16]) + 18'(c) - 18'h0_8000;
    calib = sum[17] ? 16'h0000 : (sum[16] ? 16'hFFFF : sum[15:0]);
  endfunction : calib

  // channel fan-out mask for an addressed write
  function automatic logic [39:0] fan_mask(input logic [1:0] fan, input logic [5:0] ch);
    logic [39:0] m;
    m = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      unique case (fan)
        FAN_ONE:    m[i] = (6'(i) == ch);
        FAN_GROUP:  m[i] = (6'(i / GRP_CH) == ch);
        FAN_ACROSS: m[i] = (6'(i % GRP_CH) == ch);
        FAN_ALL:    m[i] = 1'b1;
      endcase
    end
    fan_mask = m;
  endfunction : fan_mask

  // ------------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------------
  wire         wr_data  = reg_wr_i && reg_addr_i == ADDR_INPUT && state_reg != DUS_RESTORE;
  wire         wr_ctrl  = reg_wr_i && reg_addr_i == ADDR_CTRL;
  wire         wr_sel   = reg_wr_i && reg_addr_i >= ADDR_SRCSEL
                          && reg_addr_i < ADDR_SRCSEL + 8'(NUM_GRP);
  wire [1:0]   w_kind   = reg_wdata_i[17:16];
  wire [39:0]  w_mask   = fan_mask(reg_wdata_i[25:24], reg_wdata_i[23:18]);
  wire         bank     = ctrl_reg[CTRL_BANK_BIT];
  wire [2:0]   sel_grp  = 3'(reg_addr_i - ADDR_SRCSEL);

  // ------------------------------------------------------------------
  // busy and load decisions
  // ------------------------------------------------------------------
  wire any_pend   = |pend_a_reg || |pend_b_reg;
  wire own_busy   = state_reg != DUS_IDLE || any_pend || sel_busy_reg;
  wire line_busy  = own_busy || !bsy_s_reg[1];
  wire ld_event   = !clr_low && (ld_fall || ld_pend_reg || ld_level);
  wire do_load    = ld_event && !line_busy;

  assign busy_n_o    = 1'b0;
  assign busy_n_oe_o = own_busy;

  // ------------------------------------------------------------------
  // control register and source select
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctrl_reg   <= '0;
      srcsel_reg <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= reg_wdata_i[2:0];
      if (wr_sel) begin
        for (int g = 0; g < NUM_GRP; g++)
          if (sel_grp == 3'(g)) srcsel_reg[g*GRP_CH +: GRP_CH] <= reg_wdata_i[7:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // select write busy pulse
  // ------------------------------------------------------------------
  logic [7:0] sel_cnt_reg;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sel_cnt_reg  <= '0;
      sel_busy_reg <= 1'b0;
    end else if (wr_sel) begin
      sel_cnt_reg  <= 8'(STAGE_CYC - 1);
      sel_busy_reg <= 1'b1;
    end else if (sel_cnt_reg != 0) begin
      sel_cnt_reg <= sel_cnt_reg - 8'd1;
    end else begin
      sel_busy_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // load latch and clear state
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || rst_pin_low) begin
      ld_pend_reg <= 1'b0;
      cleared_reg <= 1'b1;
    end else begin
      if (clr_low) begin
        ld_pend_reg <= 1'b0;
        cleared_reg <= 1'b1;
      end else if (do_load) begin
        ld_pend_reg <= 1'b0;
        cleared_reg <= 1'b0;
      end else if (ld_fall) begin
        ld_pend_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // sequencer: restore then shared engine
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || rst_pin_low) begin
      state_reg    <= DUS_RESTORE;
      cnt_reg      <= '0;
      ch_reg       <= '0;
      bank_cur_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        DUS_RESTORE: begin
          if (cnt_reg == RESET_SEQ_CYC - 1) begin
            state_reg <= DUS_IDLE;
            cnt_reg   <= '0;
          end else begin
            cnt_reg <= cnt_reg + 32'd1;
          end
        end
        DUS_IDLE: begin
          // the idle cycle counts as the first cycle of the first stage
          if (any_pend) begin
            state_reg <= DUS_CALC;
            cnt_reg   <= 32'd1;
          end
        end
        DUS_CALC: begin
          if (cnt_reg == STAGE_CYC - 1) begin
            cnt_reg <= '0;
            if (!any_pend) state_reg <= DUS_TAIL;
          end else begin
            cnt_reg <= cnt_reg + 32'd1;
          end
        end
        DUS_TAIL: begin
          // the empty calc stage after the last channel was stage channels+1
          if (cnt_reg == TAIL_CYC - 1) begin
            state_reg <= DUS_IDLE;
            cnt_reg   <= '0;
          end else begin
            cnt_reg <= cnt_reg + 32'd1;
          end
        end
      endcase
    end
  end

  // pick next pending channel, bank a first
  logic [5:0] pick_ch;
  logic       pick_b;
  always_comb begin
    pick_ch = '0;
    pick_b  = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pend_b_reg[i]) begin
        pick_ch = 6'(i);
        pick_b  = 1'b1;
      end
    end
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pend_a_reg[i]) begin
        pick_ch = 6'(i);
        pick_b  = 1'b0;
      end
    end
  end
  wire calc_step = state_reg == DUS_CALC && cnt_reg == STAGE_CYC - 1 && any_pend;

  // ------------------------------------------------------------------
  // data registers, pending flags and calibrated words
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || rst_pin_low || state_reg == DUS_RESTORE) begin
      for (int i = 0; i < NUM_CH; i++) begin
        in_a_reg[i]   <= INPUT_DEFAULT;
        in_b_reg[i]   <= INPUT_DEFAULT;
        gain_a_reg[i] <= GAIN_DEFAULT;
        gain_b_reg[i] <= GAIN_DEFAULT;
        off_a_reg[i]  <= OFFSET_DEFAULT;
        off_b_reg[i]  <= OFFSET_DEFAULT;
        cal_a_reg[i]  <= DAC_DEFAULT;
        cal_b_reg[i]  <= DAC_DEFAULT;
      end
      pend_a_reg  <= '0;
      pend_b_reg  <= '0;
      changed_reg <= '0;
    end else begin
      // engine step retires one channel
      if (calc_step) begin
        if (pick_b) begin
          cal_b_reg[pick_ch]  <= calib(in_b_reg[pick_ch], gain_b_reg[pick_ch],
                                       off_b_reg[pick_ch]);
          pend_b_reg[pick_ch] <= 1'b0;
        end else begin
          cal_a_reg[pick_ch]  <= calib(in_a_reg[pick_ch], gain_a_reg[pick_ch],
                                       off_a_reg[pick_ch]);
          pend_a_reg[pick_ch] <= 1'b0;
        end
        changed_reg[pick_ch] <= 1'b1;
      end
      if (do_load) changed_reg <= '0;
      if (calc_step && do_load) changed_reg[pick_ch] <= 1'b1;           // set wins
      // writes accepted even while busy
      if (wr_data) begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (w_mask[i]) begin
            unique case (w_kind)
              KIND_INPUT:  if (bank) in_b_reg[i] <= reg_wdata_i[15:0];
                           else      in_a_reg[i] <= reg_wdata_i[15:0];
              KIND_OFFSET: if (bank) off_b_reg[i] <= reg_wdata_i[15:0];
                           else      off_a_reg[i] <= reg_wdata_i[15:0];
              KIND_GAIN:   if (bank) gain_b_reg[i] <= reg_wdata_i[15:0];
                           else      gain_a_reg[i] <= reg_wdata_i[15:0];
              default: ;
            endcase
            if (w_kind != 2'b00) begin
              if (bank) pend_b_reg[i] <= 1'b1;
              else      pend_a_reg[i] <= 1'b1;
            end
          end
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // dac registers: changed-only load, untouched by clear
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || rst_pin_low) begin
      for (int i = 0; i < NUM_CH; i++) dac_reg[i] <= DAC_DEFAULT;
    end else if (do_load) begin
      for (int i = 0; i < NUM_CH; i++)
        if (changed_reg[i])
          dac_reg[i] <= srcsel_reg[i] ? cal_b_reg[i] : cal_a_reg[i];
    end
  end

  // ------------------------------------------------------------------
  // output drive
  // ------------------------------------------------------------------
  logic ground_all;
  always_comb begin
    ground_all = rst_pin_low || state_reg == DUS_RESTORE || clr_low
                 || cleared_reg || ctrl_reg[CTRL_PD_BIT];
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      out_connect_o  <= 1'b0;
      out_ground_o   <= '1;
      powered_down_o <= 1'b0;
    end else begin
      out_connect_o  <= !(rst_pin_low || ctrl_reg[CTRL_PD_BIT]);
      out_ground_o   <= {NUM_CH{ground_all}};
      powered_down_o <= ctrl_reg[CTRL_PD_BIT];
    end
  end
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) channel_outputs_o[i*16 +: 16] = dac_reg[i];
  end

  // ------------------------------------------------------------------
  // read port
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_CTRL:   reg_rdata_o <= {29'h0, ctrl_reg};
        ADDR_STATUS: reg_rdata_o <= {26'h0, ld_pend_reg, cleared_reg, !line_busy,
                                     own_busy, state_reg};
        default:     reg_rdata_o <= (wr_sel || !(reg_addr_i >= ADDR_SRCSEL
                                     && reg_addr_i < ADDR_SRCSEL + 8'(NUM_GRP))) ? 32'h0
                                    : {24'h0, srcsel_reg[sel_grp*GRP_CH +: GRP_CH]};
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end
endmodule : dus_sequencer
`default_nettype wire

// file: tb/dus_busy_peer.sv
// dus_busy_peer: a second device sharing the wired busy line
// assumes start_i is a one-cycle request from the bench
`timescale 1ns/1ns
`default_nettype none
module dus_busy_peer (
  input  wire logic        clk_sys_i,
  input  wire logic        start_i,
  input  wire logic [15:0] hold_cyc_i,
  input  wire logic        dut_oe_i,
  output logic             busy_n_o
);
  logic [15:0] hold_reg = 16'h0000;
  // count down the span the peer keeps computing
  always_ff @(posedge clk_sys_i) begin
    if (start_i) begin
      hold_reg <= hold_cyc_i;
    end else if (hold_reg != 16'h0000) begin
      hold_reg <= hold_reg - 16'h0001;
    end
  end
  // pull-up line: low while either party pulls it
  assign busy_n_o = !(dut_oe_i || (hold_reg != 16'h0000));
endmodule : dus_busy_peer
`default_nettype wire

// file: tb/dus_seq_monitor.sv
// dus_seq_monitor: port assertions for the update sequencer
// assumes busy_n_i carries the resolved wired busy line
`timescale 1ns/1ns
`default_nettype none
module dus_seq_monitor (
  input wire logic         clk_sys_i,
  input wire logic         reset_i,
  input wire logic         reset_pin_n_i,
  input wire logic         zero_outputs_n_i,
  input wire logic         load_outputs_n_i,
  input wire logic         busy_n_i,
  input wire logic         busy_n_o,
  input wire logic         busy_n_oe_o,
  input wire logic [7:0]   reg_addr_i,
  input wire logic [31:0]  reg_wdata_i,
  input wire logic         reg_wr_i,
  input wire logic         reg_rd_i,
  input wire logic [31:0]  reg_rdata_o,
  input wire logic         out_connect_o,
  input wire logic [39:0]  out_ground_o,
  input wire logic [639:0] channel_outputs_o,
  input wire logic         powered_down_o
);
  import dus_pkg::*;
  logic [2:0] low_cnt;
  logic       pd_bit_q;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // consecutive cycles the wired line has been low, and last power-down bit written
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      low_cnt <= 3'd0;
    end else begin
      low_cnt <= busy_n_i ? 3'd0 : ((low_cnt == 3'd7) ? 3'd7 : low_cnt + 3'd1);
    end
    if (reg_wr_i && reg_addr_i == ADDR_CTRL) begin
      pd_bit_q <= reg_wdata_i[CTRL_PD_BIT];
    end
  end
  a_busy_pin_low: assert property (busy_n_o == 1'b0)
    else $error("busy pin drive value not low");
  a_pin_grounds: assert property (
    (!reset_pin_n_i)[*5] |-> (out_ground_o == '1) && !out_connect_o)
    else $error("reset pin low left outputs connected");
  a_pd_grounds: assert property (
    powered_down_o && $past(powered_down_o) |-> (out_ground_o == '1) && !out_connect_o)
    else $error("power-down left outputs connected");
  a_pd_follows: assert property (
    reg_wr_i && reg_addr_i == ADDR_CTRL |=> ##1 powered_down_o == pd_bit_q)
    else $error("power-down flag does not follow control write");
  a_clear_grounds: assert property ((!zero_outputs_n_i)[*5] |-> out_ground_o == '1)
    else $error("clear low left outputs live");
  a_clear_holds: assert property (
    (!zero_outputs_n_i)[*6] |=> $stable(channel_outputs_o))
    else $error("dac registers moved while clear low");
  a_busy_holds: assert property (
    low_cnt >= 3'd6 && out_ground_o == '0 |-> $stable(channel_outputs_o))
    else $error("outputs updated while busy line low");
  a_sel_busy: assert property (
    reg_wr_i && reg_addr_i >= ADDR_SRCSEL && reg_addr_i <= ADDR_SRCSEL + 8'd4 && !busy_n_oe_o
    |-> ##[1:3] busy_n_oe_o ##100 busy_n_oe_o ##[1:50] !busy_n_oe_o)
    else $error("select write busy pulse wrong length");
  a_write_busy: assert property (
    reg_wr_i && reg_addr_i == ADDR_INPUT && reg_wdata_i[25:24] == FAN_ONE
    && reg_wdata_i[17:16] != 2'b00 && !busy_n_oe_o
    |-> ##[1:3] busy_n_oe_o ##[1:312] !busy_n_oe_o)
    else $error("single channel busy pulse missing or too long");
  c_fan_all: cover property (reg_wr_i && reg_addr_i == ADDR_INPUT && reg_wdata_i[25:24] == FAN_ALL);
  c_load_busy: cover property ($fell(load_outputs_n_i) && !busy_n_i);
  c_power_down: cover property ($rose(powered_down_o));
endmodule : dus_seq_monitor
bind dus_sequencer dus_seq_monitor dus_seq_monitor_i (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reset_pin_n_i(reset_pin_n_i),
  .zero_outputs_n_i(zero_outputs_n_i), .load_outputs_n_i(load_outputs_n_i),
  .busy_n_i(busy_n_i), .busy_n_o(busy_n_o), .busy_n_oe_o(busy_n_oe_o),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .out_connect_o(out_connect_o),
  .out_ground_o(out_ground_o), .channel_outputs_o(channel_outputs_o),
  .powered_down_o(powered_down_o));
`default_nettype wire

// file: tb/dus_sequencer_test.sv
// dus_sequencer_test: self-checking bench for the update sequencer
// assumes a 250 MHz clock and one peer device on the wired busy line
`timescale 1ns/1ns
`default_nettype none
module dus_sequencer_test;
  import dus_pkg::*;
  logic         clk_sys_i = 1'b0;
  logic         reset_i = 1'b1;
  logic         reset_pin_n_i = 1'b1;
  logic         zero_outputs_n_i = 1'b1;
  logic         load_outputs_n_i = 1'b1;
  logic         reg_wr_i = 1'b0;
  logic         reg_rd_i = 1'b0;
  logic         peer_start = 1'b0;
  logic [7:0]   reg_addr_i = 8'h00;
  logic [31:0]  reg_wdata_i = 32'h0000_0000;
  wire logic    busy_line, busy_drv, busy_oe, out_connect, powered_down;
  wire logic [31:0]  reg_rdata;
  wire logic [39:0]  out_ground;
  wire logic [639:0] dacs;
  int           failures = 0;
  int           n_tests = 0;
  dus_sequencer dus_sequencer_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reset_pin_n_i(reset_pin_n_i),
    .zero_outputs_n_i(zero_outputs_n_i), .load_outputs_n_i(load_outputs_n_i),
    .busy_n_i(busy_line), .busy_n_o(busy_drv), .busy_n_oe_o(busy_oe),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata), .out_connect_o(out_connect),
    .out_ground_o(out_ground), .channel_outputs_o(dacs), .powered_down_o(powered_down));
  dus_busy_peer dus_busy_peer_i (.clk_sys_i(clk_sys_i), .start_i(peer_start),
    .hold_cyc_i(16'h03E8), .dut_oe_i(busy_oe), .busy_n_o(busy_line));
  // clock, then a watchdog sized to the restore plus all scenarios
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #390000;
    failures++;
    $display("mismatch %0t watchdog expired", $time);
    wrap_up();
  end
  task chk(input bit ok, input string m);
    n_tests++;
    if (!ok) begin
      failures++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc
  function automatic logic [15:0] dac(input int i);
    return dacs[16*i +: 16];
  endfunction : dac
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata === e, "read data");
    @(posedge clk_sys_i);
  endtask : rd
  // data write word: value, kind, channel and fan-out
  task dw(input logic [1:0] k, input logic [5:0] ch, input logic [1:0] f, input logic [15:0] v);
    wr(ADDR_INPUT, {6'b000000, f, ch, k, v});
  endtask : dw
  // wait for the wired line to go idle, counting the busy cycles
  task idle(output int n);
    n = 0;
    cyc(2);
    while (busy_line !== 1'b1 && n < 80000) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(busy_line === 1'b1, "busy line stuck");
  endtask : idle
  task pulse;
    load_outputs_n_i <= 1'b0;
    cyc(2);
    load_outputs_n_i <= 1'b1;
    cyc(8);
  endtask : pulse
  task t_restore;
    int n;
    cyc(20);
    chk(busy_oe === 1'b1 && out_ground === '1 && dac(0) === DAC_DEFAULT, "restore");
    dw(KIND_INPUT, 6'd1, FAN_ONE, 16'h0ABC);
    idle(n);
    chk(n > 74000, "restore too short");
    chk(out_ground === '1 && dac(0) === DAC_DEFAULT, "defaults");
  endtask : t_restore
  task t_write;
    int n;
    dw(KIND_INPUT, 6'd5, FAN_ONE, 16'h1234);
    pulse();
    chk(dac(5) === DAC_DEFAULT, "update while busy");
    idle(n);
    chk(n <= 2 * STAGE_CYC + TAIL_CYC, "busy too long");
    cyc(8);
    chk(dac(5) === 16'h1234 && dac(1) === DAC_DEFAULT && out_ground === '0, "load");
    dw(KIND_INPUT, 6'd5, FAN_ONE, 16'h5678);
    idle(n);
    cyc(8);
    chk(dac(5) === 16'h1234, "second update without load");
  endtask : t_write
  task t_fan;
    int n;
    logic [1:0] fans [4] = '{FAN_ONE, FAN_GROUP, FAN_ACROSS, FAN_ALL};
    int chans [4] = '{1, 8, 5, 40};
    load_outputs_n_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      dw(KIND_INPUT, 6'd0, fans[i], 16'h2460 + 16'(i));
      idle(n);
      chk(n >= chans[i] * STAGE_CYC && n <= (chans[i] + 1) * STAGE_CYC + TAIL_CYC, "fan");
    end
    cyc(8);
    chk(dac(0) === 16'h2463 && dac(39) === 16'h2463, "held load");
    load_outputs_n_i <= 1'b1;
    cyc(4);
  endtask : t_fan
  task t_clear;
    int n;
    zero_outputs_n_i <= 1'b0;
    cyc(6);
    chk(out_ground === '1, "clear grounds");
    dw(KIND_INPUT, 6'd7, FAN_ONE, 16'h0777);
    idle(n);
    pulse();
    chk(dac(7) === 16'h2463, "load during clear");
    zero_outputs_n_i <= 1'b1;
    cyc(6);
    chk(out_ground === '1, "cleared after release");
    pulse();
    chk(out_ground === '0 && dac(7) === 16'h0777 && dac(0) === 16'h2463, "after clear");
  endtask : t_clear
  task t_bank;
    int n;
    dw(KIND_GAIN, 6'd2, FAN_ONE, 16'h7FFF);
    idle(n);
    dw(KIND_OFFSET, 6'd2, FAN_ONE, 16'h8010);
    idle(n);
    dw(KIND_INPUT, 6'd2, FAN_ONE, 16'h1000);
    idle(n);
    wr(ADDR_CTRL, 32'h0000_0004);
    dw(KIND_INPUT, 6'd3, FAN_ONE, 16'h3333);
    idle(n);
    rd(ADDR_SRCSEL + 8'h01, 32'h0000_0000);
    rd(ADDR_CTRL, 32'h0000_0004);
    rd(8'h77, 32'h0000_0000);
    wr(ADDR_SRCSEL, 32'h0000_0008);
    idle(n);
    chk(n >= 100 && n <= 140, "select busy");
    pulse();
    chk(dac(2) === 16'h0810 && dac(3) === 16'h3333, "trim and bank");
    wr(ADDR_CTRL, 32'h0000_0000);
  endtask : t_bank
  task t_wired;
    int n;
    peer_start <= 1'b1;
    @(posedge clk_sys_i);
    peer_start <= 1'b0;
    dw(KIND_INPUT, 6'd4, FAN_ONE, 16'h0444);
    pulse();
    cyc(400);
    chk(dac(4) === 16'h2463, "update while peer busy");
    idle(n);
    cyc(8);
    chk(dac(4) === 16'h0444, "stored load");
  endtask : t_wired
  task t_pd;
    wr(ADDR_CTRL, 32'h0000_0001);
    cyc(3);
    chk(powered_down === 1'b1 && out_ground === '1 && out_connect === 1'b0, "pd");
    wr(ADDR_CTRL, 32'h0000_0000);
    cyc(3);
    chk(out_ground === '0 && out_connect === 1'b1 && dac(4) === 16'h0444, "wake");
    reset_pin_n_i <= 1'b0;
    cyc(6);
    chk(out_connect === 1'b0 && out_ground === '1, "reset pin");
  endtask : t_pd
  task wrap_up;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_restore();
    t_write();
    t_fan();
    t_clear();
    t_bank();
    t_wired();
    t_pd();
    wrap_up();
  end
endmodule : dus_sequencer_test
`default_nettype wire
